// File: core/smb_cfg_regs.svh
// Register offsets, field positions and reset values of the configuration bank.
// Assumes inclusion by its bare name from the decoder and bank modules.
`ifndef SMB_CFG_REGS_SVH
`define SMB_CFG_REGS_SVH
`define OFF_BASE_ADDR 8'h90
`define OFF_HOST_CFG 8'hD2
`define OFF_SLAVE_CMD 8'hD3
`define OFF_SHADOW_ONE 8'hD4
`define OFF_SHADOW_TWO 8'hD5
`define OFF_REVISION 8'hD6
`define BASE_RESET 32'h00000001
`define BYTE_RESET 8'h00
`define BASE_FIELD_HI 15
`define BASE_FIELD_LO 4
`define ROUTE_SMI 3'h0
`define ROUTE_IRQ9 3'h4
`define REVISION_DEFAULT 8'h5A
`endif

// File: core/smb_cfg_pkg.sv
// Types shared by the configuration bank, its assertion checker and the bench.
// Assumes the offset header sits beside it.
package smb_cfg_pkg;
    // Configuration cycle request as seen by the bank.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] offset;
        logic [3:0] byte_en;
        logic [31:0] wdata;
    } cfg_req_t;
    typedef enum logic [1:0] {
        route_smi,
        route_irq9,
        route_reserved
    } route_t;
endpackage

// File: core/smb_cfg_decode.sv
// Byte-lane decoder: says which configuration byte a dword access reaches.
// Assumes dword-aligned configuration cycles with byte enables.
`timescale 1ns/1ps
`include "smb_cfg_regs.svh"
module smb_cfg_decode (
    input wire logic [7:0] offset,
    input wire logic [3:0] byte_en,
    input wire logic [7:0] target,
    output logic hit,
    output logic [1:0] lane
);
    always_comb begin
        hit = (offset[7:2] == target[7:2]) && byte_en[target[1:0]];
        lane = target[1:0];
    end
endmodule

// File: core/smb_cfg_bank.sv
// Configuration register bank of the system-management-bus controller.
// Assumes one clean config request per cycle on ref_clk, synchronous srst.
// Behaviour
// - Base register bits 31:16 read zero
// - Base field compared with address 15:4
// - Base bits 3:1 always read zero
// - Base bit 0 fixed one, I/O
// - Route field: 000 SMI, 100 IRQ9
// - Host interface enable bit, resets clear
// - Slave command byte matched at port 10h
// - Shadow one address in bits 7:1
// - Shadow two address in bits 7:1
// - Shadow direction bits kept zero by software
// - Revision byte is read-only identifier
`timescale 1ns/1ps
`include "smb_cfg_regs.svh"
module smb_cfg_bank #(
    // Arbitrary revision value, not tied to any part.
    parameter logic [7:0] REVISION = `REVISION_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire smb_cfg_pkg::cfg_req_t req,
    input wire logic [15:0] io_addr,
    input wire logic io_valid,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_cmd,
    output logic [31:0] rdata,
    output logic rvalid,
    output logic io_block_hit,
    output logic host_interface_enable,
    output logic [2:0] interrupt_route_select,
    output logic route_smi,
    output logic route_irq9,
    output logic shadow_one_hit,
    output logic shadow_two_hit,
    output logic slave_cmd_hit
);
    // ********************************************
    // State
    // ********************************************
    typedef struct packed {
        logic [11:0] base_field;
        logic [2:0] interrupt_route_select;
        logic host_interface_enable;
        logic [7:0] slave_command_value;
        logic [6:0] shadow_one_address;
        logic shadow_one_direction;
        logic [6:0] shadow_two_address;
        logic shadow_two_direction;
        logic [31:0] rdata;
        logic rvalid;
        logic io_block_hit;
        logic route_smi;
        logic route_irq9;
        logic shadow_one_hit;
        logic shadow_two_hit;
        logic slave_cmd_hit;
    } state_t;

    state_t st;
    state_t next_st;
    logic [5:0] hit;
    logic [1:0] lane [6];
    logic [7:0] targets [6];
    // Write byte that each decoder slot picks from its own lane of the dword.
    logic [7:0] wbyte [6];
    assign targets[0] = `OFF_BASE_ADDR;
    assign targets[1] = `OFF_BASE_ADDR + 8'h01;
    assign targets[2] = `OFF_HOST_CFG;
    assign targets[3] = `OFF_SLAVE_CMD;
    assign targets[4] = `OFF_SHADOW_ONE;
    assign targets[5] = `OFF_SHADOW_TWO;

    // ********************************************
    // Elaboration checks
    // ********************************************
    // The base field is stored as twelve bits; a header that moves its edges
    // would leave the stored field and the I/O decode compare out of step.
    generate
        if ((`BASE_FIELD_HI - `BASE_FIELD_LO) != 11) begin : g_bad_base
            $error("base field must span twelve address bits");
        end
    endgenerate

    // ********************************************
    // Byte-lane decode
    // ********************************************
    // One decoder per writable byte; the lane never changes for a slot, but
    // keeping it in the decoder lets an offset move without touching this code.
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_dec
            assign wbyte[g] = lane_byte(req.wdata, lane[g]);
            smb_cfg_decode u_dec (
                .offset(req.offset),
                .byte_en(req.byte_en),
                .target(targets[g]),
                .hit(hit[g]),
                .lane(lane[g])
            );
        end
    endgenerate

    // ********************************************
    // Helpers
    // ********************************************
    // Picks one byte of a dword by lane number.
    function automatic logic [7:0] lane_byte(input logic [31:0] d, input logic [1:0] l);
        lane_byte = d[8*l +: 8];
    endfunction

    // Read value of one configuration byte; unmapped bytes read zero, so a
    // probe of a hole in the space never returns stale bus data.
    function automatic logic [7:0] reg_byte(input state_t s, input logic [7:0] off, input logic [7:0] rev);
        case (off)
            `OFF_BASE_ADDR: reg_byte = {s.base_field[3:0], 3'h0, 1'b1};
            `OFF_BASE_ADDR + 8'h01: reg_byte = s.base_field[11:4];
            `OFF_HOST_CFG: reg_byte = {4'h0, s.interrupt_route_select, s.host_interface_enable};
            `OFF_SLAVE_CMD: reg_byte = s.slave_command_value;
            `OFF_SHADOW_ONE: reg_byte = {s.shadow_one_address, s.shadow_one_direction};
            `OFF_SHADOW_TWO: reg_byte = {s.shadow_two_address, s.shadow_two_direction};
            `OFF_REVISION: reg_byte = rev;
            default: reg_byte = 8'h00;
        endcase
    endfunction

    // ********************************************
    // Next state
    // ********************************************
    always_comb begin
        next_st = st;
        if (req.wr) begin
            // Low base byte: only bits 7:4 are storage, bits 3:0 are fixed.
            if (hit[0]) begin
                next_st.base_field[3:0] = wbyte[0][7:4];
            end
            if (hit[1]) begin
                next_st.base_field[11:4] = wbyte[1];
            end
            // Upper base bytes have no storage at all, so no slot decodes them.
            if (hit[2]) begin
                next_st.host_interface_enable = wbyte[2][0];
                next_st.interrupt_route_select = wbyte[2][3:1];
            end
            if (hit[3]) begin
                next_st.slave_command_value = wbyte[3];
            end
            if (hit[4]) begin
                next_st.shadow_one_address = wbyte[4][7:1];
                next_st.shadow_one_direction = wbyte[4][0];
            end
            if (hit[5]) begin
                next_st.shadow_two_address = wbyte[5][7:1];
                next_st.shadow_two_direction = wbyte[5][0];
            end
        end
        // Read data is built from the present state, so a read and a write
        // taken together return the value from before the write.
        // Disabled byte lanes read zero.
        next_st.rvalid = req.rd;
        next_st.rdata = 32'h00000000;
        if (req.rd) begin
            for (int b = 0; b < 4; b++) begin
                if (req.byte_en[b]) begin
                    next_st.rdata[8*b +: 8] = reg_byte(st, {req.offset[7:2], 2'(b)}, REVISION);
                end
            end
        end
        next_st.io_block_hit = io_valid &&
            (io_addr[`BASE_FIELD_HI:`BASE_FIELD_LO] == st.base_field);
        // Routing outputs stay low while the host interface is disabled, so a
        // half-programmed byte never raises an interrupt path.
        // Reserved select codes raise neither output.
        // interrupt routing
        next_st.route_smi = st.host_interface_enable && (st.interrupt_route_select == `ROUTE_SMI);
        next_st.route_irq9 = st.host_interface_enable && (st.interrupt_route_select == `ROUTE_IRQ9);
        next_st.shadow_one_hit = (bus_addr[7:1] == st.shadow_one_address);
        next_st.shadow_two_hit = (bus_addr[7:1] == st.shadow_two_address);
        next_st.slave_cmd_hit = (bus_cmd == st.slave_command_value);
    end

    // ********************************************
    // Registers
    // ********************************************
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st <= '0;
            st.base_field <= 12'(`BASE_RESET >> `BASE_FIELD_LO);
        end else begin
            st <= next_st;
        end
    end

    // ********************************************
    // Outputs
    // ********************************************
    // Every output is a field of the registered state, so none has a
    // combinational path from the request or match inputs.
    assign rdata = st.rdata;
    assign rvalid = st.rvalid;
    assign io_block_hit = st.io_block_hit;
    assign host_interface_enable = st.host_interface_enable;
    assign interrupt_route_select = st.interrupt_route_select;
    assign route_smi = st.route_smi;
    assign route_irq9 = st.route_irq9;
    assign shadow_one_hit = st.shadow_one_hit;
    assign shadow_two_hit = st.shadow_two_hit;
    assign slave_cmd_hit = st.slave_cmd_hit;
endmodule

// File: verif/smb_cfg_chk.sv
// Assertion checker of the configuration bank, bound to every instance.
// Assumes only the bank's ports; it mirrors the stored bytes from the writes it sees.
`timescale 1ns/1ps
module smb_cfg_chk #(
    parameter logic [7:0] REVISION = 8'h00
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire smb_cfg_pkg::cfg_req_t req,
    input wire logic [15:0] io_addr,
    input wire logic io_valid,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_cmd,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic io_block_hit,
    input wire logic host_interface_enable,
    input wire logic [2:0] interrupt_route_select,
    input wire logic route_smi,
    input wire logic route_irq9,
    input wire logic shadow_one_hit,
    input wire logic shadow_two_hit,
    input wire logic slave_cmd_hit
);
    logic [11:0] base;
    logic [7:0] cmd, sh1, sh2;
    logic [3:0] cfg, be;
    logic [31:0] d, bm;
    logic [5:0] dw;
    logic io_m, s1_m, s2_m, c_m;
    assign dw = req.offset[7:2];
    assign be = req.byte_en;
    assign d = req.wdata;
    assign bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    assign io_m = io_valid && io_addr[15:4] == base;
    assign s1_m = bus_addr[7:1] == sh1[7:1];
    assign s2_m = bus_addr[7:1] == sh2[7:1];
    assign c_m = bus_cmd == cmd;
    // Reserved bits 7:4 of the host byte are not mirrored, they must read back zero.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            {base, cmd, sh1, sh2, cfg} <= '0;
        end else if (req.wr) begin
            if (dw == 6'h24) base <= {be[1] ? d[15:8] : base[11:4], be[0] ? d[7:4] : base[3:0]};
            if (dw == 6'h34) {cmd, cfg} <= {be[3] ? d[31:24] : cmd, be[2] ? d[19:16] : cfg};
            if (dw == 6'h35) {sh2, sh1} <= {be[1] ? d[15:8] : sh2, be[0] ? d[7:0] : sh1};
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    chk_base_read: assert property (req.rd && dw == 6'h24 |=>
        rvalid && rdata == ({16'h0000, $past(base), 4'h1} & $past(bm)))
        else $error("base read wrong");
    chk_host_read: assert property (req.rd && dw == 6'h34 |=>
        rdata == ({$past(cmd), 4'h0, $past(cfg), 16'h0000} & $past(bm)))
        else $error("host dword read wrong");
    chk_rev_read: assert property (req.rd && dw == 6'h35 |=>
        rdata == ({8'h00, REVISION, $past(sh2), $past(sh1)} & $past(bm)))
        else $error("shadow dword read wrong");
    chk_io_decode: assert property (1'b1 |=> io_block_hit == $past(io_m))
        else $error("io block hit wrong");
    chk_shadow_one: assert property (1'b1 |=> shadow_one_hit == $past(s1_m))
        else $error("shadow one hit wrong");
    chk_shadow_two: assert property (1'b1 |=> shadow_two_hit == $past(s2_m))
        else $error("shadow two hit wrong");
    chk_cmd_match: assert property (1'b1 |=> slave_cmd_hit == $past(c_m))
        else $error("command hit wrong");
    chk_host_level: assert property ({interrupt_route_select, host_interface_enable} == cfg)
        else $error("host level wrong");
    chk_route_lag: assert property (1'b1 |=> {route_smi, route_irq9} == {$past(cfg) == 4'h1, $past(cfg) == 4'h9})
        else $error("route output wrong");
endmodule
bind smb_cfg_bank smb_cfg_chk #(.REVISION(REVISION)) smb_cfg_chk_inst (.*);

// File: verif/tb_top.sv
// Self-checking bench of the configuration bank, random traffic with fixed corners.
// Assumes the package and offset header are compiled first; the checker binds itself.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    smb_cfg_pkg::cfg_req_t req = '0;
    logic [15:0] io_addr = 16'h0000;
    logic io_valid = 1'b0;
    logic [7:0] bus_addr = 8'h00, bus_cmd = 8'h00, cmd = 8'h00, sh1 = 8'h00, sh2 = 8'h00;
    logic [11:0] base = 12'h000;
    logic [3:0] cfg = 4'h0;
    logic [31:0] rdata;
    logic [2:0] interrupt_route_select;
    logic rvalid, io_block_hit, host_interface_enable, route_smi, route_irq9;
    logic shadow_one_hit, shadow_two_hit, slave_cmd_hit;
    logic [7:0] offs [4] = '{8'h40, 8'h90, 8'hD0, 8'hD4};
    int errors = 0;
    int checked = 0;
    smb_cfg_bank #(.REVISION(8'h3C)) smb_cfg_bank_inst (.*);
    task automatic finish_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // The expected read value is taken before the write lands, as a joint access returns old data.
    task automatic op(input logic r, w, input logic [7:0] off, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] e;
        @(negedge ref_clk);
        e = off[7:2] == 6'h24 ? {16'h0000, base, 4'h1} : off[7:2] == 6'h34 ? {cmd, 4'h0, cfg, 16'h0000}
            : off[7:2] == 6'h35 ? {8'h00, 8'h3C, sh2, sh1} : 32'h00000000;
        e = e & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        req = '{r, w, off, be, d};
        if (w && off[7:2] == 6'h24) base = {be[1] ? d[15:8] : base[11:4], be[0] ? d[7:4] : base[3:0]};
        if (w && off[7:2] == 6'h34) {cmd, cfg} = {be[3] ? d[31:24] : cmd, be[2] ? d[19:16] : cfg};
        if (w && off[7:2] == 6'h35) {sh2, sh1} = {be[1] ? d[15:8] : sh2, be[0] ? d[7:0] : sh1};
        @(negedge ref_clk);
        req = '0;
        `CHK("rvalid", r, rvalid)
        if (r) `CHK("rdata", e, rdata)
    endtask
    task automatic outs();
        @(negedge ref_clk);
        `CHK("io_hit", io_valid && io_addr[15:4] == base, io_block_hit)
        `CHK("s1_hit", bus_addr[7:1] == sh1[7:1], shadow_one_hit)
        `CHK("s2_hit", bus_addr[7:1] == sh2[7:1], shadow_two_hit)
        `CHK("cmd_hit", bus_cmd == cmd, slave_cmd_hit)
        `CHK("host", cfg, {interrupt_route_select, host_interface_enable})
        `CHK("route", {cfg == 4'h1, cfg == 4'h9}, {route_smi, route_irq9})
        io_valid = 1'($urandom);
        io_addr = $urandom_range(1) ? {base, 4'hB} : 16'($urandom);
        bus_addr = $urandom_range(1) ? (io_valid ? sh1 : sh2) : 8'($urandom);
        bus_cmd = $urandom_range(1) ? cmd : 8'($urandom);
    endtask
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        #200000;
        errors++;
        finish_test();
    end
    initial begin
        void'($urandom(32'hC8CF));
        repeat (6) @(negedge ref_clk);
        srst = 1'b0;
        op(1'b1, 1'b0, 8'h90, 4'hF, 32'h00000000);
        op(1'b1, 1'b1, 8'h90, 4'hF, 32'hFFFFFFFF);
        op(1'b1, 1'b1, 8'hD4, 4'hF, 32'hFFFFFFFF);
        op(1'b1, 1'b0, 8'hD4, 4'hF, 32'h00000000);
        for (int c = 0; c < 8; c++) begin
            op(1'b1, 1'b1, 8'hD0, 4'hC, {8'($urandom), 4'hF, 3'(c), 1'b1, 16'h0000});
            outs();
        end
        repeat (60) begin
            op(1'($urandom), 1'($urandom), offs[$urandom_range(3)], 4'($urandom), 32'($urandom));
            outs();
        end
        finish_test();
    end
endmodule
